// ### core/adcseq_pkg.sv
// Package: register map, field layout and timing constants for the converter sequencer
package adcseq_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_CONV_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CLK_SRC = 4'h1;
  localparam logic [3:0] ADDR_IRQ_CTRL = 4'h2;
  localparam logic [3:0] ADDR_RESULT_LOW = 4'h3;
  localparam logic [3:0] ADDR_RESULT_HIGH = 4'h4;
  localparam logic [3:0] ADDR_PORT_DIR = 4'h5;
  localparam logic [3:0] ADDR_RESULT_IN = 4'h6;
  // Control register fields
  localparam int CTRL_CHAN_LSB = 0;
  localparam int CTRL_PCFG_LSB = 3;
  localparam int CTRL_BUSY_BIT = 6;
  localparam int CTRL_START_BIT = 7;
  // Interrupt control fields
  localparam int IRQ_GIE_BIT = 0;
  localparam int IRQ_CIE_BIT = 1;
  localparam int IRQ_REQ_BIT = 2;
  // Divider codes and ratios
  localparam logic [1:0] DIV_CODE_2 = 2'h0;
  localparam logic [1:0] DIV_CODE_8 = 2'h1;
  localparam logic [1:0] DIV_CODE_32 = 2'h2;
  localparam logic [5:0] DIV_HALF_2 = 6'h01;
  localparam logic [5:0] DIV_HALF_8 = 6'h04;
  localparam logic [5:0] DIV_HALF_32 = 6'h10;
  // Pin configuration value making all four pins analog
  localparam logic [2:0] PCFG_ALL = 3'h4;
  localparam logic [2:0] PCFG_OFF = 3'h0;
  // Conversion lengths in converter clock periods
  localparam int CONV_LEN_8BIT = 64;
  localparam int CONV_LEN_9BIT = 76;
  localparam logic [DATA_W-1:0] RESET_CTRL = 8'h40;
  typedef enum logic [1:0] {ADCSEQ_OFF, ADCSEQ_HELD, ADCSEQ_RUN, ADCSEQ_DONE} adcseq_state_t;
endpackage

// ### core/adcseq_clkdiv.sv
// Converter clock divider: produces one-cycle tick per converter clock period
`timescale 1ns/1ps
module adcseq_clkdiv
  import adcseq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic [1:0] div_sel,
  output logic tick
);
  typedef struct packed {
    logic [5:0] cnt;
    logic phase;
    logic tick;
  } adcseq_div_t;
  adcseq_div_t r;
  adcseq_div_t next_r;
  logic [5:0] half;

  // Half-period length per divider code; code 11 leaves the clock stopped
  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (div_sel == DIV_CODE_2) begin
      half = DIV_HALF_2;
    end else if (div_sel == DIV_CODE_8) begin
      half = DIV_HALF_8;
    end else if (div_sel == DIV_CODE_32) begin
      half = DIV_HALF_32;
    end else begin
      half = 6'h00;
    end
    if (!run || half == 6'h00) begin
      next_r.cnt = 6'h00;
      next_r.phase = 1'b0;
    end else if (r.cnt + 6'h01 >= half) begin
      next_r.cnt = 6'h00;
      next_r.phase = ~r.phase;
      next_r.tick = r.phase; // One tick per full period
    end else begin
      next_r.cnt = r.cnt + 6'h01;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign tick = r.tick;
endmodule // adcseq_clkdiv

// ### core/adcseq_pins.sv
// Shared pin function: analog or digital per pin, pull-up and direction gating
`timescale 1ns/1ps
module adcseq_pins
  import adcseq_pkg::*;
(
  input wire logic [2:0] pcfg,
  input wire logic [3:0] dir_in,
  input wire logic [3:0] pullup_opt,
  output logic [3:0] analog_en,
  output logic [3:0] pullup_en,
  output logic [3:0] dir_eff,
  output logic powered
);
  // Number of analog pins follows the configuration field only
  always_comb begin
    if (pcfg >= PCFG_ALL) begin
      analog_en = 4'hF;
    end else begin
      analog_en = 4'(4'hF >> (3'h4 - pcfg));
    end
    pullup_en = pullup_opt & ~analog_en;
    dir_eff = dir_in | analog_en;
    powered = (pcfg != PCFG_OFF);
  end
endmodule // adcseq_pins

// ### core/adcseq_ctrl.sv
// Converter control sequencer: registers, start protocol, busy flag, result capture
//
// How it works
// - Converter clock is system clock divided by 2, 8 or 32; code 11 undefined.
// - Pin analog or digital use follows the pin configuration field at run time.
// - Analog pins lose their pull-up; pull-ups only on digital pins.
// - Analog pins ignore their port direction bit.
// - The re-initialisation pulse leaves the busy flag at one.
// - Conversion begins when start goes 0, 1, then back to 0.
// - Busy flag clears to zero when a conversion completes with result ready.
// - Interrupt reaches CPU only with both enables set and stack not full.
// - Conversion lasts 64 or 76 converter clock periods by variant.
// - Conversion runs in hardware while the CPU continues.
// - Pin configuration zero makes all pins digital and powers converter down.
// - Pin configuration 100 or above makes all four pins analog.
// - Start held high keeps converter in reset with busy flag at one.
// - End of conversion sets the interrupt request flag regardless of enables.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module adcseq_ctrl
  import adcseq_pkg::*;
#(
  parameter bit NINE_BIT = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [adcseq_pkg::ADDR_W-1:0] addr,
  input wire logic [adcseq_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [adcseq_pkg::DATA_W-1:0] rdata,
  input wire logic [8:0] analog_result,
  input wire logic stack_full,
  input wire logic [3:0] pullup_opt,
  output logic [3:0] analog_en,
  output logic [3:0] pullup_en,
  output logic [3:0] port_dir,
  output logic [2:0] channel_select,
  output logic conv_powered,
  output logic conv_reset,
  output logic irq
);
  import adcseq_pkg::*;

  localparam logic [6:0] CONV_LEN = NINE_BIT ? 7'(CONV_LEN_9BIT) : 7'(CONV_LEN_8BIT);

  typedef struct packed {
    adcseq_state_t state;
    logic [2:0] chan;
    logic [2:0] pcfg;
    logic start;
    logic busy;
    logic [1:0] div_sel;
    logic gie;
    logic cie;
    logic req;
    logic [3:0] dir;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [6:0] count;
    logic [8:0] sample_s1;
    logic [8:0] sample_s2;
    logic [7:0] rdata;
    logic [3:0] analog_en;
    logic [3:0] pullup_en;
    logic [3:0] port_dir;
    logic powered;
    logic creset;
    logic irq;
    logic stack_s1;
    logic stack_s2;
  } adcseq_ctrl_t;

  adcseq_ctrl_t r;
  adcseq_ctrl_t next_r;
  logic tick;
  logic [3:0] pin_analog;
  logic [3:0] pin_pullup;
  logic [3:0] pin_dir;
  logic pin_power;
  logic running;

  assign running = (r.state == ADCSEQ_RUN);

  // Converter clock tick generator
  adcseq_clkdiv u_div (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(running),
    .div_sel(r.div_sel),
    .tick(tick)
  );

  // Pin function decode from the configuration field
  adcseq_pins u_pins (
    .pcfg(r.pcfg),
    .dir_in(r.dir),
    .pullup_opt(pullup_opt),
    .analog_en(pin_analog),
    .pullup_en(pin_pullup),
    .dir_eff(pin_dir),
    .powered(pin_power)
  );

  // Read-back value of the control register
  function automatic logic [7:0] ctrl_word(input adcseq_ctrl_t s);
    logic [7:0] w;
    w = 8'h00;
    w[CTRL_CHAN_LSB +: 3] = s.chan;
    w[CTRL_PCFG_LSB +: 3] = s.pcfg;
    w[CTRL_BUSY_BIT] = s.busy;
    w[CTRL_START_BIT] = s.start;
    return w;
  endfunction

  // Register writes, start protocol and conversion sequencing
  always_comb begin
    next_r = r;
    next_r.sample_s1 = analog_result;
    next_r.sample_s2 = r.sample_s1;
    next_r.stack_s1 = stack_full;
    next_r.stack_s2 = r.stack_s1;
    // Conversion counts converter clocks in hardware; bus stays free
    if (running && tick) begin
      next_r.count = r.count + 7'h01;
    end
    if (running && tick && (r.count + 7'h01 == CONV_LEN)) begin
      next_r.state = ADCSEQ_DONE;
    end
    if (r.state == ADCSEQ_DONE) begin
      next_r.busy = 1'b0;
      next_r.req = 1'b1;
      if (NINE_BIT) begin
        next_r.res_hi = r.sample_s2[8:1];
        next_r.res_lo = {r.sample_s2[0], 7'h00};
      end else begin
        next_r.res_hi = 8'h00;
        next_r.res_lo = r.sample_s2[7:0];
      end
      next_r.state = ADCSEQ_OFF;
    end
    if (wr) begin
      if (addr == ADDR_CONV_CTRL) begin
        next_r.chan = wdata[CTRL_CHAN_LSB +: 3];
        next_r.pcfg = wdata[CTRL_PCFG_LSB +: 3];
        next_r.start = wdata[CTRL_START_BIT];
        if (wdata[CTRL_START_BIT]) begin
          next_r.state = ADCSEQ_HELD;
          next_r.busy = 1'b1;
          next_r.count = 7'h00;
        end else if (r.start && r.state == ADCSEQ_HELD) begin
          next_r.state = ADCSEQ_RUN;
          next_r.count = 7'h00;
        end
      end else if (addr == ADDR_CLK_SRC) begin
        next_r.div_sel = wdata[1:0];
      end else if (addr == ADDR_IRQ_CTRL) begin
        next_r.gie = wdata[IRQ_GIE_BIT];
        next_r.cie = wdata[IRQ_CIE_BIT];
        // Hardware set at completion wins over a software clear
        next_r.req = wdata[IRQ_REQ_BIT] | (r.state == ADCSEQ_DONE);
      end else if (addr == ADDR_PORT_DIR) begin
        next_r.dir = wdata[3:0];
      end
    end
    // Converter powered down while no pin is analog
    if (!pin_power && next_r.state == ADCSEQ_RUN) begin
      next_r.state = ADCSEQ_OFF;
    end
    // Registered outputs
    next_r.analog_en = pin_analog;
    next_r.pullup_en = pin_pullup;
    next_r.port_dir = pin_dir;
    next_r.powered = pin_power;
    next_r.creset = (r.state == ADCSEQ_HELD);
    next_r.irq = r.req && r.gie && r.cie && !r.stack_s2;
    // Read data one cycle after the strobe; unmapped reads return zero
    next_r.rdata = 8'h00;
    if (rd) begin
      if (addr == ADDR_CONV_CTRL) begin
        next_r.rdata = ctrl_word(r);
      end else if (addr == ADDR_CLK_SRC) begin
        next_r.rdata = {6'h00, r.div_sel};
      end else if (addr == ADDR_IRQ_CTRL) begin
        next_r.rdata = {5'h00, r.req, r.cie, r.gie};
      end else if (addr == ADDR_RESULT_LOW) begin
        next_r.rdata = r.res_lo;
      end else if (addr == ADDR_RESULT_HIGH) begin
        next_r.rdata = r.res_hi;
      end else if (addr == ADDR_PORT_DIR) begin
        next_r.rdata = {4'h0, r.dir};
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.busy <= RESET_CTRL[CTRL_BUSY_BIT];
      r.dir <= 4'hF;
      r.port_dir <= 4'hF;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
  assign analog_en = r.analog_en;
  assign pullup_en = r.pullup_en;
  assign port_dir = r.port_dir;
  assign channel_select = r.chan;
  assign conv_powered = r.powered;
  assign conv_reset = r.creset;
  assign irq = r.irq;
endmodule // adcseq_ctrl

// ### dv/adcseq_chk.sv
// Checker: port-level assertions for the converter sequencer
`timescale 1ns/1ps
module adcseq_chk
  import adcseq_pkg::*;
#(
  parameter bit NINE_BIT = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [adcseq_pkg::ADDR_W-1:0] addr,
  input wire logic [adcseq_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic stack_full,
  input wire logic [3:0] pullup_opt,
  input wire logic [3:0] analog_en,
  input wire logic [3:0] pullup_en,
  input wire logic [3:0] port_dir,
  input wire logic conv_powered,
  input wire logic conv_reset,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ctrl_wr;
  // Control register write taken this edge
  assign ctrl_wr = ce && wr && addr == ADDR_CONV_CTRL;
  // Pin function relations
  AST_NO_PU_ANALOG: assert property ((pullup_en & analog_en) == 4'h0) else $error("pull-up on analog pin");
  AST_PU_FOLLOW: assert property ($past(rst_n) && $past(ce) && $stable(analog_en)
    |-> pullup_en == ($past(pullup_opt) & ~analog_en)) else $error("pull-up mismatch");
  AST_DIR_OVERRIDE: assert property ((port_dir & analog_en) == analog_en) else $error("direction not forced");
  AST_POWER: assert property (conv_powered == (analog_en != 4'h0)) else $error("power mismatch");
  AST_ALL_ANALOG: assert property (ctrl_wr && wdata[5:3] >= PCFG_ALL
    |-> ##[1:2] analog_en == 4'hF) else $error("not all analog");
  AST_OFF: assert property (ctrl_wr && wdata[5:3] == PCFG_OFF
    |-> ##[1:2] (analog_en == 4'h0 && !conv_powered)) else $error("not powered down");
  // Start protocol and interrupt gating
  AST_HOLD: assert property (ctrl_wr && wdata[CTRL_START_BIT] |-> ##[1:3] conv_reset) else $error("no hold");
  AST_RELEASE: assert property (ctrl_wr && !wdata[CTRL_START_BIT] && conv_reset
    |-> ##[1:2] !conv_reset) else $error("hold stuck");
  AST_STACK: assert property (stack_full [*5] |-> !irq) else $error("irq with full stack");
endmodule // adcseq_chk

bind adcseq_ctrl adcseq_chk #(.NINE_BIT(NINE_BIT)) u_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
  .wdata(wdata), .wr(wr), .stack_full(stack_full), .pullup_opt(pullup_opt), .analog_en(analog_en),
  .pullup_en(pullup_en), .port_dir(port_dir), .conv_powered(conv_powered), .conv_reset(conv_reset), .irq(irq));

// ### dv/testbench.sv
// Testbench: self-checking run of the converter sequencer
`timescale 1ns/1ps
module testbench;
  import adcseq_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, stack_full = 1'b0, ce = 1'b1;
  logic [3:0] addr = 4'h0, pullup_opt = 4'h0, m, analog_en, pullup_en, port_dir;
  logic [7:0] wdata = 8'h00, rdata, d;
  logic [8:0] analog_result = 9'h000;
  logic [2:0] channel_select;
  logic conv_powered, conv_reset, irq;
  logic [31:0] lfsr = 32'h8A62C319;
  int n_errors = 0, check_count = 0, cyc = 0, t0, dur, div, k;
  adcseq_ctrl #(.NINE_BIT(1'b0)) uut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .analog_result(analog_result), .stack_full(stack_full),
    .pullup_opt(pullup_opt), .analog_en(analog_en), .pullup_en(pullup_en), .port_dir(port_dir),
    .channel_select(channel_select), .conv_powered(conv_powered), .conv_reset(conv_reset), .irq(irq));
  // Clock and cycle count
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Register port cycles
  task automatic wr_reg(logic [3:0] a, logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(ADDR_CONV_CTRL, d);
    check("ctrl", d, RESET_CTRL);
    wr_reg(ADDR_RESULT_LOW, 8'hFF);
    rd_reg(ADDR_RESULT_LOW, d);
    check("ro", d, 8'h00);
    rd_reg(ADDR_RESULT_IN, d);
    check("unmapped", d, 8'h00);
    $display("test reset done");
    // Every pin configuration with random pull-ups and directions
    for (int p = 0; p < 8; p++) begin
      lfsr = lfsr_next(lfsr);
      pullup_opt <= lfsr[3:0];
      m = (p >= 4) ? 4'hF : 4'((1 << p) - 1);
      wr_reg(ADDR_PORT_DIR, {4'h0, lfsr[7:4]});
      d = 8'(p << 3) | {6'h00, lfsr[9:8]};
      wr_reg(ADDR_CONV_CTRL, d);
      // A nonzero pin change is followed by a start pulse
      if (p != 0) begin
        wr_reg(ADDR_CONV_CTRL, d | 8'h80);
        wr_reg(ADDR_CONV_CTRL, d);
        rd_reg(ADDR_CONV_CTRL, d);
        check("reinit", d[CTRL_BUSY_BIT], 1'b1);
      end
      repeat (3) @(posedge clk);
      #1;
      check("analog", analog_en, m);
      check("pullup", pullup_en, lfsr[3:0] & ~m);
      check("dir", port_dir, lfsr[7:4] | m);
      check("pwr", conv_powered, p != 0);
      check("chan", channel_select, lfsr[9:8]);
    end
    $display("test pins done");
    // Conversions at each divider with each interrupt gate
    for (int i = 0; i < 4; i++) begin
      div = (i == 1) ? 8 : (i == 2) ? 32 : 2;
      lfsr = lfsr_next(lfsr);
      analog_result <= lfsr[8:0];
      stack_full <= (i == 3);
      wr_reg(ADDR_CLK_SRC, 8'(i % 3));
      wr_reg(ADDR_IRQ_CTRL, {6'h00, i != 1, i != 2});
      wr_reg(ADDR_CONV_CTRL, 8'hA0);
      rd_reg(ADDR_CONV_CTRL, d);
      check("held", d[CTRL_BUSY_BIT], 1'b1);
      check("creset", conv_reset, 1'b1);
      wr_reg(ADDR_CONV_CTRL, 8'h20);
      t0 = cyc;
      rd_reg(ADDR_CONV_CTRL, d);
      check("busy", d[CTRL_BUSY_BIT], 1'b1);
      k = 0;
      while (d[CTRL_BUSY_BIT] === 1'b1 && k < 1200) begin
        rd_reg(ADDR_CONV_CTRL, d);
        k++;
      end
      if (k == 1200) begin
        n_errors++;
        stop_test();
      end
      dur = cyc - t0;
      check("length", dur >= 63 * div && dur <= 66 * div + 10, 1'b1);
      rd_reg(ADDR_RESULT_LOW, d);
      check("result", d, lfsr[7:0]);
      analog_result <= ~lfsr[8:0];
      rd_reg(ADDR_RESULT_HIGH, d);
      check("res_hi", d, 8'h00);
      rd_reg(ADDR_RESULT_LOW, d);
      check("hold", d, lfsr[7:0]);
      rd_reg(ADDR_IRQ_CTRL, d);
      check("req", d[IRQ_REQ_BIT], 1'b1);
      check("irq", irq, i == 0);
    end
    $display("test conversion done");
    // Clock enable low: a register write is ignored
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(ADDR_CLK_SRC, 8'h01);
    ce <= 1'b1;
    rd_reg(ADDR_CLK_SRC, d);
    check("freeze", d, 8'h00);
    $display("test clock enable done");
    wr_reg(ADDR_CONV_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    check("off", conv_powered, 1'b0);
    $display("test power down done");
    stop_test();
  end
endmodule // testbench
